// ==== core/bvps_pkg.sv ====
package bvps_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CONFIG = 4'h0;
  localparam logic [3:0] OFS_DELAYS = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // config field positions
  localparam int CFG_BURNER_LSB = 0;
  localparam int CFG_PUMP_BYPASS = 2;
  localparam int CFG_TWIN = 3;
  localparam int CFG_RET_MIX = 4;
  localparam int CFG_CHECKBACK = 5;
  localparam int CFG_PUMP_FOLLOWS = 6;
  localparam int CFG_MAINT_CLOSED = 7;
  localparam int CFG_OVL_EN = 8;
  localparam int CFG_FLOW_EN = 9;
  localparam int CFG_CHKB_LSB = 16;
  // delays field positions
  localparam int DLY_PUMP_LSB = 0;
  localparam int DLY_BURNER_LSB = 8;
  localparam int DLY_OVERRUN_LSB = 16;
  // reset values
  localparam logic [31:0] CONFIG_RESET = 32'h0078_0000;
  localparam logic [31:0] DELAYS_RESET = 32'h0000_0000;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int CHKB_DEFAULT_S = 120;
  localparam int FLOW_PROVE_TICKS = 2;
  // burner styles and sequencer states
  typedef enum logic [1:0] {BVPS_ONE_STAGE, BVPS_TWO_STAGE, BVPS_MOD_3POS, BVPS_MOD_CONT} bvps_burner_t;
  typedef enum logic [2:0] {BVPS_IDLE, BVPS_VALVE_OPEN, BVPS_PUMP_RUN, BVPS_FIRING, BVPS_OVERRUN, BVPS_FAULT} bvps_state_t;
  // plant drive outputs
  typedef struct packed {
    logic stage1;
    logic stage2;
    logic mod_more;
    logic mod_less;
    logic pump_a;
    logic pump_b;
    logic valve_open;
    logic valve_close;
    logic mix_open;
    logic mix_close;
  } bvps_drive_t;
endpackage

// ==== core/bvps_sequencer.sv ====
// Functional notes
// - default single-stage burner; config selects two-stage, three-position or continuous modulating
// - first burner output is stage one and modulating base-stage enable
// - three-position modulating burner uses a more/less output pair
// - boiler pump always present; parallel or bypass function selectable
// - return-mixing plant drives a three-position open/close valve pair
// - twin pumps drive a separate second pump output
// - overload input, flow switch, or both supervise the pumps
// - without release the return mixing valve is driven fully closed
// - shutoff valve drives complementary open and close contacts
// - following pump starts only after valve confirmed open
// - valve opens fully before burner; only a following pump waits for it
// - valve counts open on checkback or expired pump delay
// - missing checkback at start delay expiry gives valve and boiler fault
// - pump start delay in seconds, reset value zero
// - burner release delay in seconds, reset value zero
// - bypass pump accepts zero delay, starts without waiting for valve
// - maintained return valve setting open or closed, default open
// - pump starts at pump delay, burner after burner delay
// - one overrun time for pump and shutoff valve
// - burner only starts while configured checkback shows valve open
// - boiler locked while release input is passive
// - open setting opens valve whenever burner runs
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module bvps_sequencer
  import bvps_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  input wire logic CLK, // system clock
  input wire logic RSTN, // async reset, low
  input wire logic [3:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read strobe
  input wire logic AVS_WRITE, // write strobe
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
  output logic [31:0] AVS_READDATA, // read data
  output logic AVS_WAITREQUEST, // stall
  input wire logic RELEASE_IN, // external release
  input wire logic HEAT_REQ, // heat request
  input wire logic STAGE2_REQ, // second stage demand
  input wire logic MOD_UP, // firing up demand
  input wire logic MOD_DOWN, // firing down demand
  input wire logic VALVE_CHECKBACK, // valve fully open
  input wire logic PUMP_OVERLOAD, // pump overload
  input wire logic PUMP_FLOW, // flow switch
  output bvps_drive_t DRIVE, // plant outputs
  output logic VALVE_FAULT, // valve fault
  output logic BOILER_FAULT // boiler fault
);
  logic [31:0] cfg;
  logic [31:0] dly;
  logic fault_clear;
  logic rd_ack;
  logic [31:0] next_rdata;
  logic [25:0] tick_cnt;
  logic tick;
  logic [15:0] seq_timer;
  logic [15:0] chkb_timer;
  logic [15:0] chkb_limit;
  bvps_state_t state;
  bvps_burner_t burner;
  logic pump_fault;
  logic valve_ok;
  logic burner_on;
  logic released;
  logic pump_on;
  logic valve_on;
  logic valve_fault_set;
  logic [1:0] flow_wait;
  logic flow_armed;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // m.s field to seconds
  function automatic logic [15:0] ms_to_s(input logic [15:0] f);
    return 16'(f[15:8] * 60) + 16'(f[7:0]);
  endfunction

  assign burner = bvps_burner_t'(cfg[CFG_BURNER_LSB +: 2]);
  assign chkb_limit = ms_to_s(cfg[CFG_CHKB_LSB +: 16]);
  assign released = RELEASE_IN & HEAT_REQ & ~BOILER_FAULT;
  assign pump_fault = (cfg[CFG_OVL_EN] & PUMP_OVERLOAD) | (cfg[CFG_FLOW_EN] & pump_on & flow_armed & ~PUMP_FLOW);

  // avalon slave: writes take effect at once, reads answer one cycle later
  assign AVS_WAITREQUEST = AVS_READ & ~rd_ack;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      rd_ack <= 1'b0;
    else
      rd_ack <= AVS_READ & ~rd_ack;
  end

  // config and delay registers
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cfg <= CONFIG_RESET;
      dly <= DELAYS_RESET;
    end
    else if (AVS_WRITE)
    begin
      if (AVS_ADDRESS == OFS_CONFIG)
        cfg <= merge(cfg, AVS_WRITEDATA, AVS_BYTEENABLE);
      else if (AVS_ADDRESS == OFS_DELAYS)
        dly <= merge(dly, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'h00FF_FFFF;
    end
  end

  assign fault_clear = AVS_WRITE && AVS_ADDRESS == OFS_CONTROL && AVS_BYTEENABLE[0] && AVS_WRITEDATA[0];

  // read mux
  always_comb
  begin
    if (AVS_ADDRESS == OFS_CONFIG)
      next_rdata = cfg;
    else if (AVS_ADDRESS == OFS_DELAYS)
      next_rdata = dly;
    else if (AVS_ADDRESS == OFS_STATUS)
      next_rdata = {16'h0000, 8'(state), 5'h00, pump_fault, BOILER_FAULT, VALVE_FAULT};
    else
      next_rdata = 32'h0000_0000;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      AVS_READDATA <= 32'h0000_0000;
    else if (AVS_READ & ~rd_ack)
      AVS_READDATA <= next_rdata;
  end

  // one-second tick
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end
    else if (tick_cnt == 26'(TICK_COUNT - 1))
    begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 26'd1;
      tick <= 1'b0;
    end
  end

  // valve open when checkback seen or, without checkback, pump delay gone
  assign valve_ok = cfg[CFG_CHECKBACK] ? VALVE_CHECKBACK : (seq_timer >= 16'(dly[DLY_PUMP_LSB +: 8]));

  // sequencer
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state <= BVPS_IDLE;
      seq_timer <= '0;
    end
    else
    begin
      case (state)
        BVPS_IDLE:
        begin
          seq_timer <= '0;
          if (released)
            state <= BVPS_VALVE_OPEN;
        end
        BVPS_VALVE_OPEN:
        begin
          if (!released)
          begin
            state <= BVPS_OVERRUN;
            seq_timer <= '0;
          end
          else if (cfg[CFG_PUMP_BYPASS] && dly[DLY_PUMP_LSB +: 8] == 8'h00)
          begin
            state <= BVPS_PUMP_RUN;
            seq_timer <= '0;
          end
          else if (seq_timer >= 16'(dly[DLY_PUMP_LSB +: 8]) && (valve_ok || !cfg[CFG_PUMP_FOLLOWS]))
          begin
            state <= BVPS_PUMP_RUN;
            seq_timer <= '0;
          end
          else if (tick)
            seq_timer <= seq_timer + 16'd1;
        end
        BVPS_PUMP_RUN:
        begin
          if (!released)
          begin
            state <= BVPS_OVERRUN;
            seq_timer <= '0;
          end
          else if (seq_timer >= 16'(dly[DLY_BURNER_LSB +: 8]) && (!cfg[CFG_CHECKBACK] || VALVE_CHECKBACK))
            state <= BVPS_FIRING;
          else if (tick)
            seq_timer <= seq_timer + 16'd1;
        end
        BVPS_FIRING:
        begin
          seq_timer <= '0;
          if (!released)
            state <= BVPS_OVERRUN;
        end
        BVPS_OVERRUN:
        begin
          if (released)
            state <= BVPS_VALVE_OPEN;
          else if (seq_timer >= 16'(dly[DLY_OVERRUN_LSB +: 8]))
            state <= BVPS_IDLE;
          else if (tick)
            seq_timer <= seq_timer + 16'd1;
        end
        default:
          state <= BVPS_IDLE;
      endcase
    end
  end

  // checkback supervision timer, runs while the valve is commanded open
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      chkb_timer <= '0;
    else if (!valve_on || VALVE_CHECKBACK)
      chkb_timer <= '0;
    else if (tick && chkb_timer < chkb_limit)
      chkb_timer <= chkb_timer + 16'd1;
  end

  // flow switch judged only after the pump has run for the proving time
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      flow_wait <= '0;
    else if (!pump_on)
      flow_wait <= '0;
    else if (tick && !flow_armed)
      flow_wait <= flow_wait + 2'd1;
  end

  assign flow_armed = flow_wait == 2'(FLOW_PROVE_TICKS);

  // checkback still missing once the start delay has run out
  assign valve_fault_set = cfg[CFG_CHECKBACK] && valve_on && !VALVE_CHECKBACK && chkb_timer >= chkb_limit;

  // faults: set beats clear, each flag on its own
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      VALVE_FAULT <= 1'b0;
      BOILER_FAULT <= 1'b0;
    end
    else
    begin
      if (valve_fault_set)
        VALVE_FAULT <= 1'b1;
      else if (fault_clear)
        VALVE_FAULT <= 1'b0;
      if (valve_fault_set || pump_fault)
        BOILER_FAULT <= 1'b1;
      else if (fault_clear)
        BOILER_FAULT <= 1'b0;
    end
  end

  assign burner_on = state == BVPS_FIRING;
  assign pump_on = state == BVPS_PUMP_RUN || state == BVPS_FIRING || state == BVPS_OVERRUN
    || (state == BVPS_VALVE_OPEN && cfg[CFG_PUMP_BYPASS] && dly[DLY_PUMP_LSB +: 8] == 8'h00);
  // maintained-return closed setting keeps the valve shut unless there is a request
  assign valve_on = (state != BVPS_IDLE) && !(cfg[CFG_MAINT_CLOSED] && !HEAT_REQ)
    || (burner_on && !cfg[CFG_MAINT_CLOSED]);

  // registered plant outputs
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      DRIVE <= '0;
    else
    begin
      DRIVE.stage1 <= burner_on;
      DRIVE.stage2 <= burner_on && burner == BVPS_TWO_STAGE && STAGE2_REQ;
      DRIVE.mod_more <= burner_on && burner == BVPS_MOD_3POS && MOD_UP && !MOD_DOWN;
      DRIVE.mod_less <= burner == BVPS_MOD_3POS && (!burner_on || (MOD_DOWN && !MOD_UP));
      DRIVE.pump_a <= pump_on;
      DRIVE.pump_b <= pump_on && cfg[CFG_TWIN];
      DRIVE.valve_open <= valve_on;
      DRIVE.valve_close <= !valve_on;
      DRIVE.mix_open <= cfg[CFG_RET_MIX] && released && burner_on && MOD_UP;
      DRIVE.mix_close <= cfg[CFG_RET_MIX] && !released;
    end
  end

  // release lost while firing, then the two-edge output response
  sequence release_lost_s;
    state == BVPS_FIRING && !released;
  endsequence
  sequence burner_off_s;
    ##2 !DRIVE.stage1;
  endsequence
  sequence pump_held_s;
    ##2 DRIVE.pump_a;
  endsequence

  // output relations
  burner_valve_a: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(state == BVPS_FIRING) && cfg[CFG_CHECKBACK] |-> $past(VALVE_CHECKBACK))
    else $error("burner started without valve checkback");
  lock_release_a: assert property (@(posedge CLK) disable iff (!RSTN)
    !RELEASE_IN |=> !(state == BVPS_FIRING))
    else $error("burner firing while release passive");
  burner_stop_a: assert property (@(posedge CLK) disable iff (!RSTN)
    release_lost_s |-> burner_off_s)
    else $error("burner not stopped on release loss");
  mix_closed_a: assert property (@(posedge CLK) disable iff (!RSTN)
    cfg[CFG_RET_MIX] && !released |=> DRIVE.mix_close)
    else $error("mixing valve not closed");
  valve_pair_a: assert property (@(posedge CLK) disable iff (!RSTN)
    $past(RSTN) |-> DRIVE.valve_open != DRIVE.valve_close)
    else $error("shutoff contacts not complementary");
  twin_pump_a: assert property (@(posedge CLK) disable iff (!RSTN)
    DRIVE.pump_b |-> DRIVE.pump_a)
    else $error("pump b without pump a");
  valve_fault_a: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(VALVE_FAULT) |-> BOILER_FAULT)
    else $error("valve fault without boiler fault");
  pump_order_a: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(state == BVPS_PUMP_RUN) && !cfg[CFG_PUMP_BYPASS] |-> $past(seq_timer) >= 16'(dly[DLY_PUMP_LSB +: 8]))
    else $error("pump started before delay");

  // sequencing and fault relations
  pump_overrun_a: assert property (@(posedge CLK) disable iff (!RSTN)
    release_lost_s |-> pump_held_s)
    else $error("pump not held through overrun");
  pump_follow_a: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(state == BVPS_PUMP_RUN) && cfg[CFG_PUMP_FOLLOWS] && !cfg[CFG_PUMP_BYPASS] |-> $past(valve_ok))
    else $error("following pump started before valve open");
  mod_pair_a: assert property (@(posedge CLK) disable iff (!RSTN)
    !(DRIVE.mod_more && DRIVE.mod_less))
    else $error("more and less driven together");
  stage2_base_a: assert property (@(posedge CLK) disable iff (!RSTN)
    DRIVE.stage2 |-> DRIVE.stage1)
    else $error("stage two without stage one");
  valve_open_a: assert property (@(posedge CLK) disable iff (!RSTN)
    burner_on && !cfg[CFG_MAINT_CLOSED] |=> DRIVE.valve_open)
    else $error("valve shut while burner runs");
  valve_latch_a: assert property (@(posedge CLK) disable iff (!RSTN)
    VALVE_FAULT && !fault_clear |=> VALVE_FAULT)
    else $error("valve fault lost without clear");
  pump_fault_a: assert property (@(posedge CLK) disable iff (!RSTN)
    pump_fault |=> BOILER_FAULT)
    else $error("pump fault did not raise boiler fault");
endmodule
`default_nettype wire

// ==== testbench/bvps_plant_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module bvps_plant_model
  import bvps_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rstn, // reset, low
  input wire bvps_drive_t drive, // device outputs
  input wire logic mute, // contact broken
  input wire logic [7:0] lag, // valve travel
  output logic checkback, // valve open
  output logic flow // flow switch
);
  logic [7:0] travel;
  // valve travel, contact only once fully open
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      travel <= 8'h00;
      checkback <= 1'b0;
    end
    else
    begin
      travel <= !drive.valve_open ? 8'h00 : (travel == lag) ? travel : travel + 8'h01;
      checkback <= drive.valve_open && !mute && travel == lag;
    end
  end
  // flow switch follows either pump
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flow <= 1'b0;
    else
      flow <= drive.pump_a | drive.pump_b;
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bvps_pkg::*;
  localparam int TK = 10;
  localparam int S1 = 9;
  localparam int S2 = 8;
  localparam int PA = 5;
  localparam int PB = 4;
  localparam int VO = 3;
  localparam int VC = 2;
  localparam int MC = 0;
  localparam int VF = 11;
  localparam int BF = 10;
  localparam int MM = 7;
  localparam int ML = 6;
  localparam int MO = 1;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic rel = 1'b0;
  logic heat = 1'b0;
  logic st2 = 1'b0;
  logic mute = 1'b0;
  logic up = 1'b0;
  logic ovl = 1'b0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic wait_req;
  logic chk;
  logic flow;
  logic vf;
  logic bf;
  bvps_drive_t drv;
  wire logic [11:0] obs = {vf, bf, drv};
  int errors = 0;
  int samples_checked = 0;
  // clock
  always #12.5 clk = ~clk;
  bvps_sequencer #(.TICK_COUNT(TK)) bvps_sequencer_inst (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .RELEASE_IN(rel), .HEAT_REQ(heat), .STAGE2_REQ(st2), .MOD_UP(up),
    .MOD_DOWN(1'b0), .VALVE_CHECKBACK(chk), .PUMP_OVERLOAD(ovl), .PUMP_FLOW(flow), .DRIVE(drv),
    .VALVE_FAULT(vf), .BOILER_FAULT(bf));
  bvps_plant_model bvps_plant_model_inst (.clk(clk), .rstn(rstn), .drive(drv), .mute(mute),
    .lag(8'h03), .checkback(chk), .flow(flow));
  // verdict and end of run
  task automatic test_done;
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wr <= we;
    rd <= !we;
    wdata <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (wait_req === 1'b0)
      begin
        q = rdata;
        break;
      end
    end
    rd <= 1'b0;
    wr <= 1'b0;
    check("bus answer", 32'h0000_0000, (n == 20) ? 32'h0000_0001 : 32'h0000_0000);
    if (n == 20)
      test_done();
  endtask
  // wait for an observed bit to reach a level
  task automatic await(input int b, input logic v, input int lim);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(negedge clk);
      if (obs[b] === v)
        return;
    end
    check("wait", 32'h0000_0001, 32'h0000_0000);
    test_done();
  endtask
  task automatic t_reset;
    repeat (2) @(negedge clk);
    check("drive idle", 32'h0000_0004, {22'h0, drv});
    bus(1'b0, OFS_CONFIG, 32'h0000_0000);
    check("config", 32'h0078_0000, q);
    bus(1'b0, OFS_DELAYS, 32'h0000_0000);
    check("delays", 32'h0000_0000, q);
    bus(1'b0, 4'h2, 32'h0000_0000);
    check("unmapped", 32'h0000_0000, q);
  endtask
  task automatic t_sequence;
    bus(1'b1, OFS_DELAYS, 32'h0002_0302);
    @(posedge clk);
    heat <= 1'b1;
    rel <= 1'b1;
    await(VO, 1'b1, 50);
    check("pump early", 32'h0000_0000, drv.pump_a);
    await(VC, 1'b0, 3);
    await(PA, 1'b1, 5 * TK);
    check("valve at pump", 32'h0000_0001, drv.valve_open);
    check("burner early", 32'h0000_0000, drv.stage1);
    await(S1, 1'b1, 6 * TK);
    check("pump at burner", 32'h0000_0001, drv.pump_a);
    @(posedge clk);
    rel <= 1'b0;
    await(S1, 1'b0, 3);
    check("pump overrun", 32'h0000_0001, drv.pump_a);
    await(PA, 1'b0, 5 * TK);
    check("valve overrun", 32'h0000_0000, drv.valve_open);
  endtask
  task automatic t_fault;
    bus(1'b1, OFS_CONFIG, 32'h0003_0060);
    bus(1'b1, OFS_DELAYS, 32'h0000_0001);
    @(posedge clk);
    mute <= 1'b1;
    rel <= 1'b1;
    await(VF, 1'b1, 8 * TK);
    check("boiler fault", 32'h0000_0001, bf);
    check("burner blocked", 32'h0000_0000, drv.stage1);
    check("pump blocked", 32'h0000_0000, drv.pump_a);
    @(posedge clk);
    rel <= 1'b0;
    mute <= 1'b0;
    bus(1'b1, OFS_CONTROL, 32'h0000_0001);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    check("faults cleared", 32'h0000_0000, q & 32'h0000_0003);
  endtask
  task automatic t_twin_mix;
    bus(1'b1, OFS_CONFIG, 32'h0078_0019);
    await(MC, 1'b1, 5);
    @(posedge clk);
    st2 <= 1'b1;
    rel <= 1'b1;
    await(PA, 1'b1, 5 * TK);
    check("second pump", 32'h0000_0001, drv.pump_b);
    await(S1, 1'b1, 5 * TK);
    await(S2, 1'b1, 5);
    @(posedge clk);
    rel <= 1'b0;
    await(MC, 1'b1, 5 * TK);
  endtask
  task automatic t_modulate;
    bus(1'b1, OFS_CONFIG, 32'h0078_0352);
    await(ML, 1'b1, 5);
    @(posedge clk);
    up <= 1'b1;
    rel <= 1'b1;
    await(S1, 1'b1, 5 * TK);
    check("more", 32'h0000_0001, drv.mod_more);
    check("less", 32'h0000_0000, drv.mod_less);
    check("mix open", 32'h0000_0001, drv.mix_open);
    repeat (3 * TK) @(negedge clk);
    check("flow fault", 32'h0000_0000, bf);
    check("burner on flow", 32'h0000_0001, drv.stage1);
    @(posedge clk);
    ovl <= 1'b1;
    await(BF, 1'b1, 3);
    await(S1, 1'b0, 5);
    @(posedge clk);
    ovl <= 1'b0;
    up <= 1'b0;
    rel <= 1'b0;
    bus(1'b1, OFS_CONTROL, 32'h0000_0001);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    check("faults cleared", 32'h0000_0000, q & 32'h0000_0007);
  endtask
  // reset, then the scenarios in turn
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_sequence();
    t_fault();
    t_twin_mix();
    t_modulate();
    test_done();
  end
endmodule
`default_nettype wire
